/* File: hdl/totalize_pkg.sv */
package totalize_pkg;

    // count resolution
    localparam int COUNT_WIDTH = 64;
    localparam int GATE_MODE_W = 3;

    // clocking and pulse rate
    localparam int CLK_PERIOD_NS = 10;
    localparam int MAX_INPUT_MHZ = 48;

    // activity indicator half period
    localparam int BLINK_HALF_MS = 50;
    localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

    // reset values
    localparam logic OUT_INIT_RESET = 1'h0;
    localparam logic LED_RESET = 1'h0;

    typedef enum logic [GATE_MODE_W-1:0] {
        GATE_NONE    = 3'h0,
        GATE_DIR     = 3'h1,
        GATE_GATING  = 3'h2,
        GATE_CLEAR   = 3'h3,
        GATE_TRIGGER = 3'h4
    } gate_mode_t;

    typedef enum logic [1:0] {
        TRG_WAIT = 2'h1,
        TRG_RUN  = 2'h2
    } trig_state_t;

endpackage : totalize_pkg

/* File: hdl/pin_event_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface pin_event_if;
    logic level;
    logic rise;
    logic fall;

    modport source (
        output level,
        output rise,
        output fall
    );

    modport sink (
        input level,
        input rise,
        input fall
    );
endinterface : pin_event_if
`default_nettype wire

/* File: hdl/edge_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module edge_sync (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_pin,
    pin_event_if.source ev
);
    logic meta;
    logic sync;
    logic prev;
    logic [2:0] warm;

    // meta is read by sync alone
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta <= 1'h0;
            sync <= 1'h0;
            prev <= 1'h0;
            warm <= 3'h0;
        end else begin
            meta <= i_pin;
            sync <= meta;
            prev <= sync;
            warm <= {warm[1:0], 1'h1};
        end
    end

    // no edges until sync and prev hold real pin samples,
    // so a pin idling high gives no false edge after reset
    assign ev.level = sync;
    assign ev.rise = sync & ~prev & warm[2];
    assign ev.fall = ~sync & prev & warm[2];

    a_rise_single:
        assert property (@(posedge i_clk) disable iff (!i_resetn)
            ev.rise |=> !ev.rise)
        else $error("rise pulse lasted more than one cycle");

    a_rise_level:
        assert property (@(posedge i_clk) disable iff (!i_resetn)
            ev.rise |-> ev.level && !$past(ev.level))
        else $error("rise pulse without a low to high level");
endmodule : edge_sync
`default_nettype wire

/* File: hdl/activity_blinker.sv */
`timescale 1ns/10ps
`default_nettype none
module activity_blinker
    import totalize_pkg::*;
#(
    parameter int HALF_CYCLES = BLINK_HALF_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_active,
    output var logic o_led
);
    localparam int TW = $clog2(HALF_CYCLES + 1);
    localparam logic [TW-1:0] LAST = TW'(HALF_CYCLES - 1);

    logic [TW-1:0] tick;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tick <= '0;
            o_led <= LED_RESET;
        end else if (!i_active) begin
            tick <= '0;
            o_led <= LED_RESET;
        end else if (tick == LAST) begin
            tick <= '0;
            o_led <= ~o_led;
        end else begin
            tick <= tick + 1'h1;
        end
    end

    a_led_dark:
        assert property (@(posedge i_clk) disable iff (!i_resetn)
            !i_active |=> !o_led)
        else $error("activity led lit while idle");
endmodule : activity_blinker
`default_nettype wire

/* File: hdl/totalize_event_counter.sv */
// Function
// - count width up to 64, limit bounded
// - count input pulses up to 48 MHz
// - count input pin is the count source
// - demand and scan reads share options
// - limit writes never touch the count
// - clear on read returns prior count
// - range limit up: freeze or wrap min
// - range limit down: freeze or wrap max
// - non recycle stops at reached limit
// - reversal or reload resumes frozen counter
// - count down bit, gate direction overrides
// - output toggles at compare zero, one
// - output initial level programmable, default low
// - direction gate: high up, low down
// - gating: count only while gate high
// - gate clears to zero or min limit
// - trigger gate edge starts counting
// - gate functions only in totalize mode
// - activity led blinks only during transfers
`timescale 1ns/10ps
`default_nettype none
module totalize_event_counter
    import totalize_pkg::*;
#(
    parameter int CNT_W = COUNT_WIDTH,
    parameter int BLINK_HALF = BLINK_HALF_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic i_COUNT_INPUT_PIN,
    input wire logic i_COUNT_GATE_PIN,
    input wire logic i_TOTALIZE_EN,
    input wire logic [GATE_MODE_W-1:0] i_GATE_MODE,
    input wire logic i_GATE_INVERT,
    input wire logic i_CLEAR_ON_READ,
    input wire logic i_RANGE_LIMIT,
    input wire logic i_NON_RECYCLE,
    input wire logic i_COUNT_DOWN,
    input wire logic i_OUTPUT_ON,
    input wire logic i_OUTPUT_INIT_HIGH,
    input wire logic [CNT_W-1:0] i_MIN_LIMIT,
    input wire logic [CNT_W-1:0] i_MAX_LIMIT,
    input wire logic [CNT_W-1:0] i_OUT_CMP0,
    input wire logic [CNT_W-1:0] i_OUT_CMP1,
    input wire logic i_LOAD,
    input wire logic [CNT_W-1:0] i_LOAD_VALUE,
    input wire logic i_READ_REQ,
    input wire logic i_SCAN_REQ,
    input wire logic i_HOST_XFER,
    output var logic o_READ_VALID,
    output var logic [CNT_W-1:0] o_READ_DATA,
    output var logic [CNT_W-1:0] o_COUNT,
    output var logic o_COUNT_OUTPUT_PIN,
    output var logic o_ACTIVITY_LED
);
    localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
    localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    pin_event_if cin_ev ();
    pin_event_if cgt_ev ();

    gate_mode_t gmode;
    trig_state_t trig;
    trig_state_t next_trig;
    logic gate_lvl;
    logic gate_edge;
    logic count_up;
    logic count_en;
    logic step;
    logic gate_clear;
    logic read_req;
    logic read_clear;
    logic base_is_count;
    logic [CNT_W-1:0] clear_val;
    logic [CNT_W-1:0] base;
    logic [CNT_W-1:0] next_count;
    logic at_max;
    logic at_min;
    logic out_init;

    // pins pass a two stage synchroniser before use
    edge_sync u_cin_sync (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_pin(i_COUNT_INPUT_PIN),
        .ev(cin_ev.source)
    );

    edge_sync u_cgt_sync (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_pin(i_COUNT_GATE_PIN),
        .ev(cgt_ev.source)
    );

    activity_blinker #(
        .HALF_CYCLES(BLINK_HALF)
    ) u_blink (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_active(i_HOST_XFER),
        .o_led(o_ACTIVITY_LED)
    );

    // gate options ignored outside totalize
    assign gmode = i_TOTALIZE_EN ? gate_mode_t'(i_GATE_MODE) : GATE_NONE;
    assign gate_lvl = cgt_ev.level ^ i_GATE_INVERT;
    assign gate_edge = i_GATE_INVERT ? cgt_ev.fall : cgt_ev.rise;

    // gate level overrides the count down bit
    assign count_up = (gmode == GATE_DIR) ? gate_lvl : ~i_COUNT_DOWN;

    always_comb begin
        count_en = i_TOTALIZE_EN;
        case (gmode)
            GATE_GATING: begin
                count_en = gate_lvl;
            end
            GATE_TRIGGER: begin
                count_en = (trig == TRG_RUN);
            end
            default: begin
                count_en = i_TOTALIZE_EN;
            end
        endcase
    end

    // one count per rising edge on the input pin
    assign step = cin_ev.rise & count_en;

    assign gate_clear = (gmode == GATE_CLEAR) && gate_edge;
    assign clear_val = i_RANGE_LIMIT ? i_MIN_LIMIT : CNT_ZERO;
    assign read_req = i_READ_REQ | i_SCAN_REQ;
    assign read_clear = read_req & i_CLEAR_ON_READ;

    always_comb begin
        next_trig = trig;
        case (trig)
            TRG_WAIT: begin
                if (gmode == GATE_TRIGGER && gate_edge) begin
                    next_trig = TRG_RUN;
                end
            end
            TRG_RUN: begin
                if (gmode != GATE_TRIGGER) begin
                    next_trig = TRG_WAIT;
                end
            end
            default: begin
                next_trig = TRG_WAIT;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            trig <= TRG_WAIT;
        end else begin
            trig <= next_trig;
        end
    end

    // starting value for this cycle, before any count pulse
    always_comb begin
        base_is_count = 1'h0;
        if (gate_clear) begin
            base = clear_val;
        end else if (i_LOAD) begin
            base = i_LOAD_VALUE;
        end else if (read_clear) begin
            base = clear_val;
        end else begin
            base = o_COUNT;
            base_is_count = 1'h1;
        end
    end

    assign at_max = (base == i_MAX_LIMIT);
    assign at_min = (base == i_MIN_LIMIT);

    // limits act only when reached, never rewrite the count
    always_comb begin
        next_count = base;
        if (step && count_up) begin
            if (i_NON_RECYCLE && at_max) begin
                next_count = base;
            end else if (i_RANGE_LIMIT && at_max) begin
                next_count = i_MIN_LIMIT;
            end else begin
                next_count = base + CNT_ONE;
            end
        end else if (step) begin
            if (i_NON_RECYCLE && at_min) begin
                next_count = base;
            end else if (i_RANGE_LIMIT && at_min) begin
                next_count = i_MAX_LIMIT;
            end else begin
                next_count = base - CNT_ONE;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            o_COUNT <= CNT_ZERO;
        end else begin
            o_COUNT <= next_count;
        end
    end

    // read returns the count held before any clear
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            o_READ_VALID <= 1'h0;
            o_READ_DATA <= CNT_ZERO;
        end else begin
            o_READ_VALID <= read_req;
            if (read_req) begin
                o_READ_DATA <= o_COUNT;
            end
        end
    end

    assign out_init = i_OUTPUT_INIT_HIGH ? 1'h1 : OUT_INIT_RESET;

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            o_COUNT_OUTPUT_PIN <= OUT_INIT_RESET;
        end else if (!i_OUTPUT_ON) begin
            o_COUNT_OUTPUT_PIN <= out_init;
        end else if (o_COUNT == i_OUT_CMP0) begin
            o_COUNT_OUTPUT_PIN <= ~out_init;
        end else if (o_COUNT == i_OUT_CMP1) begin
            o_COUNT_OUTPUT_PIN <= out_init;
        end
    end

    a_read_prior:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            read_req |=> o_READ_VALID && o_READ_DATA == $past(o_COUNT))
        else $error("read did not return the prior count");

    a_read_clears:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            read_clear && !gate_clear && !i_LOAD && !step
            |=> o_COUNT == $past(clear_val))
        else $error("clear on read did not clear the counter");

    a_no_read_valid:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            !read_req |=> !o_READ_VALID)
        else $error("read valid without a request");

    a_limit_write:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            base_is_count && !step |=> $stable(o_COUNT))
        else $error("count moved without a cause");

    a_wrap_up:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            step && count_up && i_RANGE_LIMIT && !i_NON_RECYCLE
            && base_is_count && o_COUNT == i_MAX_LIMIT
            |=> o_COUNT == $past(i_MIN_LIMIT))
        else $error("up count did not wrap to min limit");

    a_wrap_down:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            step && !count_up && i_RANGE_LIMIT && !i_NON_RECYCLE
            && base_is_count && o_COUNT == i_MIN_LIMIT
            |=> o_COUNT == $past(i_MAX_LIMIT))
        else $error("down count did not wrap to max limit");

    a_stop_limit:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            step && i_NON_RECYCLE && base_is_count
            && ((count_up && o_COUNT == i_MAX_LIMIT)
            || (!count_up && o_COUNT == i_MIN_LIMIT))
            |=> $stable(o_COUNT))
        else $error("non recycle counter passed its limit");

    a_step_plain:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            step && base_is_count && o_COUNT != i_MAX_LIMIT
            && o_COUNT != i_MIN_LIMIT
            |=> o_COUNT == ($past(count_up) ? $past(o_COUNT) + CNT_ONE
                : $past(o_COUNT) - CNT_ONE))
        else $error("count pulse moved the count wrongly");

    a_dir_gate:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            gmode == GATE_DIR |-> count_up == gate_lvl)
        else $error("direction gate not followed");

    a_gating_hold:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            gmode == GATE_GATING && !gate_lvl && base_is_count
            |=> $stable(o_COUNT))
        else $error("counter moved while gated off");

    a_gate_reload:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            gate_clear && !step
            |=> o_COUNT == ($past(i_RANGE_LIMIT) ? $past(i_MIN_LIMIT)
                : CNT_ZERO))
        else $error("gate clear gave the wrong value");

    a_trig_wait:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            gmode == GATE_TRIGGER && trig == TRG_WAIT && base_is_count
            |=> $stable(o_COUNT))
        else $error("trigger counter ran before its gate edge");

    a_trig_start:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            gmode == GATE_TRIGGER && gate_edge ##1 gmode == GATE_TRIGGER
            |-> trig == TRG_RUN)
        else $error("gate edge did not start the counter");

    a_no_gate_off:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            !i_TOTALIZE_EN && base_is_count |=> $stable(o_COUNT))
        else $error("counter moved outside totalize mode");

    a_out_leave:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            i_OUTPUT_ON && o_COUNT == i_OUT_CMP0
            |=> o_COUNT_OUTPUT_PIN == !$past(out_init))
        else $error("output did not leave initial level");

    a_out_return:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            i_OUTPUT_ON && o_COUNT == i_OUT_CMP1 && o_COUNT != i_OUT_CMP0
            |=> o_COUNT_OUTPUT_PIN == $past(out_init))
        else $error("output did not return to initial level");

    a_out_idle:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            !i_OUTPUT_ON |=> o_COUNT_OUTPUT_PIN == $past(i_OUTPUT_INIT_HIGH))
        else $error("output not at its initial level");

    a_pin_latency:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            cin_ev.rise |-> $past(i_COUNT_INPUT_PIN, 2))
        else $error("count edge not from the synchronised pin");
endmodule : totalize_event_counter
`default_nettype wire

/* File: dv/pulse_source.sv */
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
    input wire logic i_clk,
    output var logic o_pin,
    output var logic o_gate
);
    initial begin
        o_pin = 1'h0;
        o_gate = 1'h0;
    end

    // pin high and low each at least one clock
    task pulses(input int n, input int hi, input int lo);
        repeat (n) begin
            @(posedge i_clk);
            o_pin <= 1'h1;
            repeat (hi) @(posedge i_clk);
            o_pin <= 1'h0;
            repeat (lo - 1) @(posedge i_clk);
        end
    endtask : pulses

    task set_gate(input logic v);
        @(posedge i_clk);
        o_gate <= v;
    endtask : set_gate
endmodule : pulse_source
`default_nettype wire

/* File: dv/totalize_event_counter_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module totalize_event_counter_tb;
    import totalize_pkg::*;
    localparam int W = 16;
    logic clk = 1'h0, rstn = 1'h0, pin, gate;
    logic en = 1'h1, ginv = 1'h0, cor = 1'h0, rl = 1'h0, nr = 1'h0;
    logic dn = 1'h0, oon = 1'h0, oih = 1'h0, ld = 1'h0;
    logic rrq = 1'h0, srq = 1'h0, xfer = 1'h0, rv, opin, led;
    logic [GATE_MODE_W-1:0] gm = 3'h0;
    logic [W-1:0] mn = 16'h0000, mx = 16'hFFFF, c0 = 16'hFFFF;
    logic [W-1:0] c1 = 16'hFFFF, lv = 16'h0000, rd, cnt;
    int mismatches = 0;
    int checks = 0;

    always #5 clk = ~clk;

    pulse_source src (.i_clk(clk), .o_pin(pin), .o_gate(gate));

    totalize_event_counter #(.CNT_W(W), .BLINK_HALF(4)) dut (
        .I_CLK(clk), .I_RESETN(rstn), .i_COUNT_INPUT_PIN(pin),
        .i_COUNT_GATE_PIN(gate), .i_TOTALIZE_EN(en), .i_GATE_MODE(gm),
        .i_GATE_INVERT(ginv), .i_CLEAR_ON_READ(cor), .i_RANGE_LIMIT(rl),
        .i_NON_RECYCLE(nr), .i_COUNT_DOWN(dn), .i_OUTPUT_ON(oon),
        .i_OUTPUT_INIT_HIGH(oih), .i_MIN_LIMIT(mn), .i_MAX_LIMIT(mx),
        .i_OUT_CMP0(c0), .i_OUT_CMP1(c1), .i_LOAD(ld), .i_LOAD_VALUE(lv),
        .i_READ_REQ(rrq), .i_SCAN_REQ(srq), .i_HOST_XFER(xfer),
        .o_READ_VALID(rv), .o_READ_DATA(rd), .o_COUNT(cnt),
        .o_COUNT_OUTPUT_PIN(opin), .o_ACTIVITY_LED(led)
    );

    task stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task chk(input string name, input logic [W-1:0] exp, got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task settle;
        repeat (5) @(posedge clk);
        #1;
    endtask : settle

    task cnt_after(input int n, input logic [W-1:0] exp);
        src.pulses(n, 1, 1);
        settle();
        chk("count", exp, cnt);
    endtask : cnt_after

    task load(input logic [W-1:0] v);
        @(posedge clk);
        ld <= 1'h1;
        lv <= v;
        @(posedge clk);
        ld <= 1'h0;
    endtask : load

    // one read; scan selects the scan-group request
    task read(input logic scan, input logic [W-1:0] exp_d, exp_c);
        @(posedge clk);
        rrq <= ~scan;
        srq <= scan;
        @(posedge clk);
        rrq <= 1'h0;
        srq <= 1'h0;
        #1;
        chk("valid", 16'h0001, {15'h0000, rv});
        chk("read data", exp_d, rd);
        chk("count after read", exp_c, cnt);
        @(posedge clk);
        #1;
        chk("valid low", 16'h0000, {15'h0000, rv});
    endtask : read

    task t_reset;
        repeat (2) @(posedge clk);
        #1;
        chk("reset count", 16'h0000, cnt);
        chk("reset led", 16'h0000, {15'h0000, led});
        chk("reset out", 16'h0000, {15'h0000, opin});
        chk("reset valid", 16'h0000, {15'h0000, rv});
        @(posedge clk);
        rstn <= 1'h1;
        settle();
        cnt_after(5, 16'h0005);
        @(posedge clk);
        en <= 1'h0;
        cnt_after(2, 16'h0005);
        @(posedge clk);
        en <= 1'h1;
    endtask : t_reset

    task t_read;
        read(1'h0, 16'h0005, 16'h0005);
        @(posedge clk);
        cor <= 1'h1;
        read(1'h0, 16'h0005, 16'h0000);
        cnt_after(3, 16'h0003);
        @(posedge clk);
        rl <= 1'h1;
        mn <= 16'h0002;
        read(1'h1, 16'h0003, 16'h0002);
        @(posedge clk);
        cor <= 1'h0;
    endtask : t_read

    task t_limits;
        @(posedge clk);
        mn <= 16'h0010;
        mx <= 16'h0020;
        settle();
        chk("limit write", 16'h0002, cnt);
        load(16'h001F);
        cnt_after(2, 16'h0010);
        @(posedge clk);
        nr <= 1'h1;
        load(16'h001F);
        cnt_after(3, 16'h0020);
        @(posedge clk);
        dn <= 1'h1;
        cnt_after(1, 16'h001F);
        @(posedge clk);
        nr <= 1'h0;
        load(16'h0011);
        cnt_after(2, 16'h0020);
        @(posedge clk);
        rl <= 1'h0;
    endtask : t_limits

    task t_gate;
        @(posedge clk);
        gm <= GATE_DIR;
        src.set_gate(1'h1);
        cnt_after(3, 16'h0023);
        src.set_gate(1'h0);
        cnt_after(2, 16'h0021);
        @(posedge clk);
        gm <= GATE_GATING;
        dn <= 1'h0;
        cnt_after(3, 16'h0021);
        src.set_gate(1'h1);
        cnt_after(2, 16'h0023);
        @(posedge clk);
        gm <= GATE_CLEAR;
        src.set_gate(1'h0);
        src.set_gate(1'h1);
        settle();
        chk("gate clear", 16'h0000, cnt);
        @(posedge clk);
        rl <= 1'h1;
        mn <= 16'h0004;
        src.set_gate(1'h0);
        src.set_gate(1'h1);
        settle();
        chk("gate reload", 16'h0004, cnt);
        @(posedge clk);
        rl <= 1'h0;
        gm <= GATE_TRIGGER;
        src.set_gate(1'h0);
        cnt_after(2, 16'h0004);
        src.set_gate(1'h1);
        cnt_after(2, 16'h0006);
        @(posedge clk);
        gm <= GATE_NONE;
    endtask : t_gate

    // inverted gate: low enables, falling edge clears
    task t_invert;
        @(posedge clk);
        ginv <= 1'h1;
        gm <= GATE_GATING;
        cnt_after(2, 16'h0006);
        src.set_gate(1'h0);
        cnt_after(2, 16'h0008);
        @(posedge clk);
        gm <= GATE_CLEAR;
        src.set_gate(1'h1);
        settle();
        chk("invert no clear", 16'h0008, cnt);
        src.set_gate(1'h0);
        settle();
        chk("invert clear", 16'h0000, cnt);
        @(posedge clk);
        gm <= GATE_NONE;
        ginv <= 1'h0;
    endtask : t_invert

    task t_output;
        chk("out default", 16'h0000, {15'h0000, opin});
        @(posedge clk);
        oon <= 1'h1;
        c0 <= 16'h0003;
        c1 <= 16'h0006;
        load(16'h0000);
        cnt_after(3, 16'h0003);
        chk("out at cmp0", 16'h0001, {15'h0000, opin});
        cnt_after(3, 16'h0006);
        chk("out at cmp1", 16'h0000, {15'h0000, opin});
        @(posedge clk);
        oon <= 1'h0;
        oih <= 1'h1;
        settle();
        chk("out init high", 16'h0001, {15'h0000, opin});
        @(posedge clk);
        oon <= 1'h1;
        load(16'h0000);
        cnt_after(3, 16'h0003);
        chk("out high at cmp0", 16'h0000, {15'h0000, opin});
    endtask : t_output

    task wait_led(input logic v);
        int i;
        for (i = 0; i < 12 && led !== v; i++) begin
            @(posedge clk);
            #1;
        end
        if (led !== v) begin
            chk("led timeout", {15'h0000, v}, {15'h0000, led});
            stop_test();
        end
    endtask : wait_led

    task t_led;
        settle();
        chk("led idle", 16'h0000, {15'h0000, led});
        @(posedge clk);
        xfer <= 1'h1;
        wait_led(1'h1);
        wait_led(1'h0);
        wait_led(1'h1);
        @(posedge clk);
        xfer <= 1'h0;
        settle();
        chk("led off", 16'h0000, {15'h0000, led});
    endtask : t_led

    initial begin
        t_reset();
        t_read();
        t_limits();
        t_gate();
        t_invert();
        t_output();
        t_led();
        stop_test();
    end
endmodule : totalize_event_counter_tb
`default_nettype wire
